// [bsupv_pkg.sv]
package bsupv_pkg;

    // clock
    localparam int CLK_MHZ       = 50;
    localparam int CLK_KHZ       = CLK_MHZ * 1000;
    localparam int CLK_PERIOD_NS = 20;

    // minimum switch times: low band 100..500 kHz, high band 1818..2222 kHz
    localparam int MIN_T_LO_NS   = 150;
    localparam int MIN_OFF_HI_NS = 40;
    localparam int MIN_ON_HI_NS  = 110;
    localparam logic [9:0] MIN_LO_CYC =
        10'((MIN_T_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] MIN_OFF_HI_CYC =
        10'((MIN_OFF_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] MIN_ON_HI_CYC =
        10'((MIN_ON_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int HI_BAND_MIN_KHZ = 1818;
    localparam logic [9:0] HI_BAND_PER = 10'(CLK_KHZ / HI_BAND_MIN_KHZ);

    // external sync window 100..2222 kHz
    localparam int SYNC_MIN_KHZ = 100;
    localparam int SYNC_MAX_KHZ = 2222;
    localparam logic [10:0] SYNC_MIN_PER  = 11'(CLK_KHZ / SYNC_MAX_KHZ);
    localparam logic [10:0] SYNC_MAX_PER  = 11'(CLK_KHZ / SYNC_MIN_KHZ);
    localparam logic [10:0] SYNC_LOSS_CYC = 11'(2 * (CLK_KHZ / SYNC_MIN_KHZ));
    localparam logic [2:0]  SYNC_LOCK_EDGES = 3'h4;

    // adaptive target, 1 lsb = 1 mV feedback-referred above the reference
    localparam logic [9:0]  TGT_MAX  = 10'h3FF;
    localparam logic [9:0]  TGT_MIN  = 10'h000;
    localparam int          INIT_PCT = 88;
    localparam logic [9:0]  TGT_INIT = 10'((1023 * INIT_PCT) / 100);
    localparam int VREF_MV    = 1210;
    localparam int FB_OVPL_MV = 1423;
    localparam int FB_OVPH_MV = 1760;
    localparam int FB_UVP_MV  = 886;
    localparam logic [10:0] OVPL_OFS = 11'(FB_OVPL_MV - VREF_MV);
    localparam logic [10:0] OVPH_OFS = 11'(FB_OVPH_MV - VREF_MV);
    localparam logic [10:0] UVP_OFS  = 11'(VREF_MV - FB_UVP_MV);
    localparam int MON_PERIOD_US = 20;
    localparam logic [15:0] MON_CYC = 16'(MON_PERIOD_US * CLK_MHZ);

    // undervoltage timer
    localparam int UVP_TIME_MS = 110;
    localparam int UVP_CYC     = UVP_TIME_MS * CLK_KHZ;

    // configuration word and reset values
    localparam int         WIDTH_LSB        = 0;
    localparam int         RATE_LSB         = 2;
    localparam logic [1:0] SPREAD_WIDTH_RST = 2'h2;
    localparam logic [1:0] SPREAD_RATE_RST  = 2'h0;
    localparam int         SS_STEPS         = 512;

    // flag bit positions
    localparam int FLG_OVPL = 0;
    localparam int FLG_OVPH = 1;
    localparam int FLG_OCP  = 2;

    typedef enum logic [2:0] {
        SW_OFF  = 3'b001,
        SW_ON   = 3'b010,
        SW_STOP = 3'b100
    } sw_state_t;

    // switching period in clock cycles from the frequency resistor code
    function automatic logic [9:0] fs_period(input logic [2:0] sel);
        case (sel)
            3'h0:    fs_period = 10'(CLK_KHZ / 400);
            3'h1:    fs_period = 10'(CLK_KHZ / 200);
            3'h2:    fs_period = 10'(CLK_KHZ / 303);
            3'h3:    fs_period = 10'(CLK_KHZ / 100);
            3'h4:    fs_period = 10'(CLK_KHZ / 500);
            3'h5:    fs_period = 10'(CLK_KHZ / 1818);
            3'h6:    fs_period = 10'(CLK_KHZ / 2000);
            default: fs_period = 10'(CLK_KHZ / 2222);
        endcase
    endfunction

    // deviation in tenths of a percent
    function automatic logic [6:0] dev_permille(input logic [1:0] w);
        case (w)
            2'h0:    dev_permille = 7'd33;
            2'h1:    dev_permille = 7'd43;
            2'h2:    dev_permille = 7'd53;
            default: dev_permille = 7'd72;
        endcase
    endfunction

    // cycles per triangle step for 200/500/800/1200 Hz
    function automatic logic [9:0] ss_div(input logic [1:0] r);
        case (r)
            2'h0:    ss_div = 10'(CLK_KHZ * 1000 / (200 * SS_STEPS));
            2'h1:    ss_div = 10'(CLK_KHZ * 1000 / (500 * SS_STEPS));
            2'h2:    ss_div = 10'(CLK_KHZ * 1000 / (800 * SS_STEPS));
            default: ss_div = 10'(CLK_KHZ * 1000 / (1200 * SS_STEPS));
        endcase
    endfunction

    // in-use sink mask per string configuration code
    function automatic logic [3:0] cfg_mask(input logic [2:0] c);
        case (c)
            3'h0:    cfg_mask = 4'hF;
            3'h1:    cfg_mask = 4'h7;
            3'h2:    cfg_mask = 4'h3;
            3'h3:    cfg_mask = 4'h5;
            3'h4:    cfg_mask = 4'h1;
            default: cfg_mask = 4'h0;
        endcase
    endfunction

endpackage

// [sync2.sv]
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // sync2

// [boost_supervisor_spread_sync.sv]
module boost_supervisor_spread_sync #(
    parameter int UVP_TIMER_CYCLES = bsupv_pkg::UVP_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        boost_sync_input_in,
    input  wire logic [3:0]  sink_output_low_in,
    input  wire logic [3:0]  sink_output_at_thr_in,
    input  wire logic [3:0]  string_fault_in,
    input  wire logic        sinks_active_in,
    input  wire logic [2:0]  string_config_select_in,
    input  wire logic [2:0]  switching_frequency_resistor_in,
    input  wire logic        overvoltage_low_level_in,
    input  wire logic        overvoltage_high_level_in,
    input  wire logic        boost_undervoltage_level_in,
    input  wire logic        current_limit_in,
    input  wire logic        peak_trip_in,
    input  wire logic        fault_recovery_done_in,
    input  wire logic        cfg_wr_in,
    input  wire logic [3:0]  cfg_wdata_in,
    input  wire logic [2:0]  flag_clear_in,
    output logic             gate_drive_out,
    output logic             sink_enable_out,
    output logic [9:0]       target_code_out,
    output logic [10:0]      overvoltage_low_level_thr_out,
    output logic [10:0]      overvoltage_high_level_thr_out,
    output logic [10:0]      uvp_thr_out,
    output logic             boost_overvoltage_low_flag_out,
    output logic             boost_overvoltage_high_flag_out,
    output logic             boost_overcurrent_flag_out,
    output logic             fault_recovery_out,
    output logic             spread_enable_out,
    output logic             ext_sync_mode_out,
    output logic [1:0]       spread_width_select_out,
    output logic [1:0]       spread_rate_select_out
);
    import bsupv_pkg::*;

    // all pin inputs pass two flops except cfg_wr_in, cfg_wdata_in, flag_clear_in and fault_recovery_done_in
    logic [24:0] s_bus;
    sync2 #(.W(25)) u_sync (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .async_in   ({boost_sync_input_in, sink_output_low_in, sink_output_at_thr_in,
                      string_fault_in, sinks_active_in, string_config_select_in,
                      switching_frequency_resistor_in, overvoltage_low_level_in,
                      overvoltage_high_level_in, boost_undervoltage_level_in,
                      current_limit_in, peak_trip_in}),
        .sync_out   (s_bus)
    );
    logic       s_sync, s_act, s_ovpl, s_ovph, s_uvp, s_climit, s_trip;
    logic [3:0] s_low, s_at, s_fault;
    logic [2:0] s_cfg, s_fset;
    assign {s_sync, s_low, s_at, s_fault, s_act, s_cfg, s_fset,
            s_ovpl, s_ovph, s_uvp, s_climit, s_trip} = s_bus;

    // ---- configuration fields
    logic [1:0] width_r, width_nxt, rate_r, rate_nxt;
    always_comb begin
        width_nxt = width_r;
        rate_nxt  = rate_r;
        if (cfg_wr_in) begin
            width_nxt = cfg_wdata_in[WIDTH_LSB +: 2];
            rate_nxt  = cfg_wdata_in[RATE_LSB +: 2];
        end
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            width_r <= SPREAD_WIDTH_RST;
            rate_r  <= SPREAD_RATE_RST;
        end else begin
            width_r <= width_nxt;
            rate_r  <= rate_nxt;
        end
    end

    // ---- sync clock detection
    logic        sync_d_r, ext_r, ext_nxt, spr_r, spr_nxt;
    logic [10:0] gap_r, gap_nxt;
    logic [2:0]  lock_r, lock_nxt;
    logic        sync_rise;
    assign sync_rise = s_sync & ~sync_d_r;
    always_comb begin
        gap_nxt  = (gap_r < SYNC_LOSS_CYC) ? gap_r + 11'h001 : gap_r;
        lock_nxt = lock_r;
        if (sync_rise) begin
            gap_nxt = 11'h000;
            if (gap_r >= SYNC_MIN_PER && gap_r <= SYNC_MAX_PER) begin
                lock_nxt = (lock_r < SYNC_LOCK_EDGES) ? lock_r + 3'h1 : lock_r;
            end else begin
                lock_nxt = 3'h0;
            end
        end else if (gap_r >= SYNC_LOSS_CYC) begin
            lock_nxt = 3'h0;
        end
        ext_nxt = (lock_nxt == SYNC_LOCK_EDGES);
        spr_nxt = s_sync & ~ext_nxt;
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_d_r <= 1'b0;
            gap_r    <= SYNC_LOSS_CYC;
            lock_r   <= 3'h0;
            ext_r    <= 1'b0;
            spr_r    <= 1'b0;
        end else begin
            sync_d_r <= s_sync;
            gap_r    <= gap_nxt;
            lock_r   <= lock_nxt;
            ext_r    <= ext_nxt;
            spr_r    <= spr_nxt;
        end
    end

    // ---- spread-spectrum triangle and effective period
    logic [9:0]  div_r, div_nxt, base_per, dev;
    logic [7:0]  ph_r, ph_nxt;
    logic        up_r, up_nxt;
    logic [16:0] dev_prod;
    logic [11:0] sweep, per_eff;
    assign base_per = fs_period(s_fset);
    assign dev_prod = 17'(base_per) * 17'(dev_permille(width_r));
    assign dev      = 10'(dev_prod / 17'd1000);
    assign sweep    = 12'((18'(dev) * 18'(ph_r)) >> 7);
    assign per_eff  = 12'(base_per) + sweep - 12'(dev);
    always_comb begin
        div_nxt = div_r + 10'h001;
        ph_nxt  = ph_r;
        up_nxt  = up_r;
        if (!spr_r) begin
            div_nxt = 10'h000;
            ph_nxt  = 8'h80;
        end else if (div_r >= ss_div(rate_r) - 10'h001) begin
            div_nxt = 10'h000;
            ph_nxt  = up_r ? ph_r + 8'h01 : ph_r - 8'h01;
            if (up_r && ph_r == 8'hFE) begin
                up_nxt = 1'b0;
            end else if (!up_r && ph_r == 8'h01) begin
                up_nxt = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_r <= 10'h000;
            ph_r  <= 8'h80;
            up_r  <= 1'b1;
        end else begin
            div_r <= div_nxt;
            ph_r  <= ph_nxt;
            up_r  <= up_nxt;
        end
    end

    // ---- faults and flags
    logic        fault_r, fault_nxt, uvp_to;
    logic [31:0] uvp_cnt_r, uvp_cnt_nxt;
    logic [2:0]  flag_r, flag_nxt, flag_set;
    assign uvp_to = s_uvp && !fault_r && (uvp_cnt_r == 32'(UVP_TIMER_CYCLES - 1));
    assign flag_set = {uvp_to, s_ovph, s_ovpl};
    always_comb begin
        uvp_cnt_nxt = (s_uvp && !fault_r && !uvp_to) ? uvp_cnt_r + 32'h1 : 32'h0;
        fault_nxt   = fault_r;
        if (fault_recovery_done_in) begin
            fault_nxt = 1'b0;
        end
        if (s_ovph || uvp_to) begin
            fault_nxt = 1'b1;
        end
        flag_nxt = (flag_r & ~flag_clear_in) | flag_set;
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fault_r   <= 1'b0;
            uvp_cnt_r <= 32'h0;
            flag_r    <= 3'h0;
        end else begin
            fault_r   <= fault_nxt;
            uvp_cnt_r <= uvp_cnt_nxt;
            flag_r    <= flag_nxt;
        end
    end

    // ---- switch control with minimum times; current limit and halt end the on time before its minimum
    sw_state_t  st_r, st_nxt;
    logic [9:0] st_cnt_r, st_cnt_nxt, per_cnt_r, per_cnt_nxt, min_on, min_off;
    logic       pend_r, pend_nxt, start, halt, hi_band, end_zone;
    assign hi_band  = base_per <= HI_BAND_PER;
    assign min_on   = hi_band ? MIN_ON_HI_CYC : MIN_LO_CYC;
    assign min_off  = hi_band ? MIN_OFF_HI_CYC : MIN_LO_CYC;
    assign start    = ext_r ? sync_rise : (12'(per_cnt_r) >= per_eff - 12'h001);
    assign end_zone = ext_r ? start : (12'(per_cnt_r) + 12'(min_off) >= per_eff);
    assign halt     = s_ovpl | fault_r;
    always_comb begin
        st_nxt      = st_r;
        pend_nxt    = pend_r | start;
        per_cnt_nxt = start ? 10'h000 : (per_cnt_r == 10'h3FF ? per_cnt_r : per_cnt_r + 10'h001);
        case (st_r)
            SW_OFF: begin
                if (halt) begin
                    st_nxt = SW_STOP;
                end else if (pend_nxt && st_cnt_r >= min_off - 10'h001) begin
                    st_nxt = SW_ON;
                end
            end
            SW_ON: begin
                if (halt) begin
                    st_nxt = SW_STOP;
                end else if (s_climit) begin
                    st_nxt = SW_OFF;
                end else if ((s_trip || end_zone) && st_cnt_r >= min_on - 10'h001) begin
                    st_nxt = SW_OFF;
                end
            end
            SW_STOP: begin
                if (!halt) begin
                    st_nxt = SW_OFF;
                end
            end
            default: st_nxt = SW_STOP;
        endcase
        if (st_nxt == SW_ON) begin
            pend_nxt = 1'b0;
        end
        st_cnt_nxt = (st_nxt != st_r) ? 10'h000
                   : (st_cnt_r == 10'h3FF ? st_cnt_r : st_cnt_r + 10'h001);
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r      <= SW_STOP;
            st_cnt_r  <= 10'h000;
            per_cnt_r <= 10'h000;
            pend_r    <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            st_cnt_r  <= st_cnt_nxt;
            per_cnt_r <= per_cnt_nxt;
            pend_r    <= pend_nxt;
        end
    end

    // ---- adaptive target
    logic [15:0] mon_r, mon_nxt;
    logic [9:0]  tgt_r, tgt_nxt;
    logic [10:0] ovpl_r, ovph_r, uvp_r;
    logic [3:0]  mask;
    logic        tick, any_low, any_at;
    assign mask    = cfg_mask(s_cfg) & ~s_fault;
    assign tick    = (mon_r == MON_CYC - 16'h0001);
    assign any_low = |(s_low & mask);
    assign any_at  = |(s_at & mask);
    always_comb begin
        mon_nxt = tick ? 16'h0000 : mon_r + 16'h0001;
        tgt_nxt = tgt_r;
        if (!s_act) begin
            tgt_nxt = TGT_INIT;
        end else if (tick && any_low) begin
            tgt_nxt = (tgt_r == TGT_MAX) ? tgt_r : tgt_r + 10'h001;
        end else if (tick && mask != 4'h0 && !any_at) begin
            tgt_nxt = (tgt_r == TGT_MIN) ? tgt_r : tgt_r - 10'h001;
        end
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mon_r  <= 16'h0000;
            tgt_r  <= TGT_INIT;
            ovpl_r <= 11'(TGT_INIT) + OVPL_OFS;
            ovph_r <= 11'(TGT_INIT) + OVPH_OFS;
            uvp_r  <= 11'(TGT_INIT) - UVP_OFS;
        end else begin
            mon_r  <= mon_nxt;
            tgt_r  <= tgt_nxt;
            ovpl_r <= 11'(tgt_nxt) + OVPL_OFS;
            ovph_r <= 11'(tgt_nxt) + OVPH_OFS;
            uvp_r  <= (11'(tgt_nxt) > UVP_OFS) ? 11'(tgt_nxt) - UVP_OFS : 11'h000;
        end
    end

    assign gate_drive_out                  = (st_r == SW_ON);
    assign sink_enable_out                 = !fault_r;
    assign target_code_out                 = tgt_r;
    assign overvoltage_low_level_thr_out                 = ovpl_r;
    assign overvoltage_high_level_thr_out                = ovph_r;
    assign uvp_thr_out                     = uvp_r;
    assign boost_overvoltage_low_flag_out  = flag_r[FLG_OVPL];
    assign boost_overvoltage_high_flag_out = flag_r[FLG_OVPH];
    assign boost_overcurrent_flag_out      = flag_r[FLG_OCP];
    assign fault_recovery_out              = fault_r;
    assign spread_enable_out               = spr_r;
    assign ext_sync_mode_out               = ext_r;
    assign spread_width_select_out         = width_r;
    assign spread_rate_select_out          = rate_r;

    // ---- checks
    property p_min_off_lo;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(gate_drive_out) && !hi_band && $stable(s_fset) |-> !gate_drive_out [*8];
    endproperty
    a_min_off_lo: assert property (p_min_off_lo) else $error("off time below minimum");
    property p_min_on;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_r == SW_ON && st_nxt == SW_OFF && !s_climit) |-> st_cnt_r >= min_on - 10'h001;
    endproperty
    a_min_on: assert property (p_min_on) else $error("on time below minimum");
    property p_step_up;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_act && tick && any_low && tgt_r != TGT_MAX |=> tgt_r == $past(tgt_r) + 10'h001;
    endproperty
    a_step_up: assert property (p_step_up) else $error("target did not step up");
    property p_hold_at;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_act && !any_low && (any_at || mask == 4'h0) |=> $stable(tgt_r);
    endproperty
    a_hold_at: assert property (p_hold_at) else $error("target moved at headroom");
    property p_init;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !s_act |=> tgt_r == TGT_INIT;
    endproperty
    a_init: assert property (p_init) else $error("initial target not held");
    property p_ovpl;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_ovpl |=> !gate_drive_out && boost_overvoltage_low_flag_out;
    endproperty
    a_ovpl: assert property (p_ovpl) else $error("low overvoltage not handled");
    property p_ovph;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_ovph |=> fault_recovery_out && boost_overvoltage_high_flag_out && !sink_enable_out;
    endproperty
    a_ovph: assert property (p_ovph) else $error("high overvoltage not handled");
    property p_thr;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ##1 overvoltage_low_level_thr_out == 11'(target_code_out) + OVPL_OFS;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold not tracking target");
    property p_uvp;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        uvp_to |=> fault_recovery_out && boost_overcurrent_flag_out;
    endproperty
    a_uvp: assert property (p_uvp) else $error("undervoltage timeout not handled");
    property p_ext_spr;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ext_r |-> !spread_enable_out;
    endproperty
    a_ext_spr: assert property (p_ext_spr) else $error("spread active with sync");
    property p_climit;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_climit && gate_drive_out |=> !gate_drive_out && (flag_r & ~$past(flag_r) & ~$past(flag_set)) == 3'h0;
    endproperty
    a_climit: assert property (p_climit) else $error("current limit mishandled");
    c_ext: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) $rose(ext_r));
    c_step: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) tick && any_low && s_act);
    c_uvp: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) uvp_to);
endmodule // boost_supervisor_spread_sync

// [pstage_model.sv]
module pstage_model (
    input  wire logic       ref_clk_in,
    input  wire logic [9:0] target_in,
    input  wire logic [9:0] need_in,
    input  wire logic [3:0] low_mask_in,
    output logic      [3:0] low_out,
    output logic      [3:0] at_thr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // sinks short of headroom while the target is under the string need
    always_ff @(posedge ref_clk_in) begin
        low_out    <= (target_in < need_in) ? low_mask_in : 4'h0;
        at_thr_out <= {4{target_in == need_in}};
    end
endmodule // pstage_model

// [boost_supervisor_spread_sync_test.sv]
module boost_supervisor_spread_sync_test;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %0h got %0h", n, e, v); end end
    logic clk = 0, rstn = 0, sync = 0, act = 0, ovl = 0, ovh = 0, uv = 0;
    logic wr = 0, done = 0, gate, sen, fl, fh, fo, fr, sp, ext;
    logic [3:0] lowm = 4'hF, flt = 4'h0, wd = 4'h0, low, at;
    logic [2:0] clr = 3'h0;
    logic cl = 0, seen = 0;
    logic [9:0] need = 10'h384, tgt;
    logic [10:0] tl, th, tu;
    logic [1:0] sw, sr;
    int error_cnt = 0, checked = 0;
    boost_supervisor_spread_sync #(.UVP_TIMER_CYCLES(200)) DUT (
        .ref_clk_in(clk), .rstn_in(rstn), .boost_sync_input_in(sync),
        .sink_output_low_in(low), .sink_output_at_thr_in(at), .string_fault_in(flt),
        .sinks_active_in(act), .string_config_select_in(3'h0),
        .switching_frequency_resistor_in(3'h0), .overvoltage_low_level_in(ovl),
        .overvoltage_high_level_in(ovh), .boost_undervoltage_level_in(uv),
        .current_limit_in(cl), .peak_trip_in(1'b0), .fault_recovery_done_in(done),
        .cfg_wr_in(wr), .cfg_wdata_in(wd), .flag_clear_in(clr), .gate_drive_out(gate),
        .sink_enable_out(sen), .target_code_out(tgt), .overvoltage_low_level_thr_out(tl),
        .overvoltage_high_level_thr_out(th), .uvp_thr_out(tu), .boost_overvoltage_low_flag_out(fl),
        .boost_overvoltage_high_flag_out(fh), .boost_overcurrent_flag_out(fo),
        .fault_recovery_out(fr), .spread_enable_out(sp), .ext_sync_mode_out(ext),
        .spread_width_select_out(sw), .spread_rate_select_out(sr));
    pstage_model PSM (.ref_clk_in(clk), .target_in(tgt), .need_in(need),
        .low_mask_in(lowm), .low_out(low), .at_thr_out(at));
    initial forever #10 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic end_fault();
        done <= 1'b1;
        cyc(1);
        done <= 1'b0;
        cyc(1);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1200000;
        error_cnt++;
        finish_test();
    end
    initial begin
        cyc(6);
        rstn <= 1'b1;
        cyc(2);
        `CHK("target", 10'h384, tgt)
        `CHK("ovpl", 11'h459, tl)
        `CHK("ovph", 11'h5AA, th)
        `CHK("uvp", 11'h240, tu)
        `CHK("ext", 1'b0, ext)
        `CHK("width", 2'h2, sw)
        `CHK("rate", 2'h0, sr)
        for (int i = 0; i < 16; i += 5) begin
            wr <= 1'b1;
            wd <= 4'(i);
            cyc(1);
            wr <= 1'b0;
            cyc(1);
            `CHK("width", 2'(i), sw)
            `CHK("rate", 2'(i >> 2), sr)
        end
        act <= 1'b1;
        need <= 10'h389;
        cyc(2500);
        `CHK("step", 1'b1, tgt <= 10'h387)
        cyc(9500);
        `CHK("up", 10'h389, tgt)
        `CHK("ovpl", 11'h45E, tl)
        need <= 10'h370;
        cyc(30000);
        `CHK("down", 10'h370, tgt)
        need <= 10'h37A;
        lowm <= 4'h8;
        flt <= 4'h8;
        cyc(3000);
        `CHK("fault", 1'b1, tgt < 10'h370)
        ovl <= 1'b1;
        cyc(4);
        `CHK("ovlf", 1'b1, fl)
        `CHK("gate", 1'b0, gate)
        `CHK("sink", 1'b1, sen)
        ovl <= 1'b0;
        cyc(200);
        `CHK("ovlf", 1'b1, fl)
        clr <= 3'h1;
        cyc(1);
        clr <= 3'h0;
        cyc(1);
        `CHK("ovlf", 1'b0, fl)
        wait (gate === 1'b1);
        cyc(1);
        cl <= 1'b1;
        cyc(5);
        `CHK("climit gate", 1'b0, gate)
        `CHK("climit ocpf", 1'b0, fo)
        cl <= 1'b0;
        repeat (300) begin
            cyc(1);
            if (gate === 1'b1) seen = 1'b1;
        end
        `CHK("climit restart", 1'b1, seen)
        `CHK("climit ocpf", 1'b0, fo)
        ovh <= 1'b1;
        cyc(4);
        `CHK("ovhf", 1'b1, fh)
        `CHK("fault", 1'b1, fr)
        `CHK("sink", 1'b0, sen)
        ovh <= 1'b0;
        cyc(4);
        end_fault();
        `CHK("fault", 1'b0, fr)
        uv <= 1'b1;
        cyc(150);
        `CHK("fault", 1'b0, fr)
        cyc(60);
        `CHK("ocpf", 1'b1, fo)
        `CHK("fault", 1'b1, fr)
        uv <= 1'b0;
        end_fault();
        sync <= 1'b1;
        cyc(4);
        `CHK("spread", 1'b1, sp)
        repeat (8) begin
            sync <= 1'b1;
            cyc(12);
            sync <= 1'b0;
            cyc(13);
        end
        `CHK("ext", 1'b1, ext)
        `CHK("spread", 1'b0, sp)
        sync <= 1'b1;
        cyc(1100);
        `CHK("ext", 1'b0, ext)
        `CHK("spread", 1'b1, sp)
        sync <= 1'b0;
        cyc(4);
        `CHK("spread", 1'b0, sp)
        finish_test();
    end
endmodule // boost_supervisor_spread_sync_test
